// File: nphy_pkg.sv
// Notes on behaviour
// [RULE_01] per-lane bit n drives lane slice n only
// [RULE_02] load value bus 54 bits, nine per lane
// [RULE_03] load taps into input or output delay
// [RULE_04] delay controls live in control clock domain
// [RULE_05] control clock runs delays and calibration
// [RULE_06] control clock ratio across bank at most 4:1
// [RULE_07] rx pad bits captured, buffered, presented per lane
// [RULE_08] 8-bit tx word serialized onto matching pad
// [RULE_09] start input chains to next nibble's start out; tb drives it from the device's own stop_out instead
// [RULE_10] stop input from previous stop out, else high
// [RULE_11] interbyte clock only from forwarding output, else one
// [RULE_12] read enable high advances fifo every cycle
package nphy_pkg;
  localparam int NPHY_LANES = 6;
  localparam int NPHY_TAP_W = 9;
  localparam int NPHY_CNT_W = NPHY_LANES * NPHY_TAP_W;
  localparam int NPHY_TX_W = 8;
  localparam int NPHY_FIFO_DEPTH = 16;
  localparam logic [NPHY_TAP_W-1:0] NPHY_TAP_RESET = 9'h000;
  localparam logic [2:0] NPHY_BIT_RESET = 3'h0;
  localparam int NPHY_CAL_CYCLES = 8;
  localparam logic [3:0] NPHY_CAL_RESET = 4'h0;
  typedef enum logic [2:0] {
    NPHY_CAL_IDLE = 3'b001,
    NPHY_CAL_RUN = 3'b010,
    NPHY_CAL_DONE = 3'b100
  } nphy_cal_state_t;
endpackage : nphy_pkg

// File: nphy_if.sv
`timescale 1ns/1ps
interface nphy_if;
  import nphy_pkg::*;
  logic [NPHY_LANES-1:0] step_enable;
  logic [NPHY_LANES-1:0] step_up;
  logic [NPHY_LANES-1:0] delay_load_strobe;
  logic [NPHY_CNT_W-1:0] delay_load_value;
  logic delay_direction_select;
  logic [NPHY_TX_W-1:0] tx_word [NPHY_LANES];
  logic [NPHY_LANES-1:0] tx_word_valid;
  logic [NPHY_LANES-1:0] tx_word_ready;
  logic [NPHY_LANES-1:0] lane_fifo_read_enable;
  logic [NPHY_LANES-1:0] rx_word_valid;
  logic [NPHY_TX_W-1:0] rx_word [NPHY_LANES];
  modport device (
    input step_enable, step_up, delay_load_strobe, delay_load_value, delay_direction_select,
    input tx_word, tx_word_valid, lane_fifo_read_enable,
    output tx_word_ready, rx_word_valid, rx_word
  );
  modport fabric (
    output step_enable, step_up, delay_load_strobe, delay_load_value, delay_direction_select,
    output tx_word, tx_word_valid, lane_fifo_read_enable,
    input tx_word_ready, rx_word_valid, rx_word
  );
endinterface : nphy_if

// File: nphy_fifo.sv
`timescale 1ns/1ps
module nphy_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : nphy_fifo

// File: nphy_device.sv
`timescale 1ns/1ps
module nphy_device
  import nphy_pkg::*;
#(
  parameter int LANES = NPHY_LANES,
  parameter int DEPTH = NPHY_FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  nphy_if.device link,
  input wire logic [LANES-1:0] rx_pad_bits_i,
  output logic [LANES-1:0] pad_serial_out_o,
  input wire logic cal_chain_start_in_i,
  input wire logic cal_chain_stop_in_i,
  output logic cal_chain_start_out_o,
  output logic cal_chain_stop_out_o,
  input wire logic interbyte_clock_in_i,
  output logic clock_forward_down_o,
  output logic clock_forward_up_o,
  output logic [LANES*NPHY_TAP_W-1:0] in_delay_taps_o,
  output logic [LANES*NPHY_TAP_W-1:0] out_delay_taps_o,
  output logic cal_done_o
);
  nphy_cal_state_t cal_q;
  logic [3:0] cal_cnt_q;
  logic [2:0] ib_sync_q;
  logic ib_level_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ib_sync_q <= 3'h0;
      ib_level_q <= 1'b0;
    end else begin
      ib_sync_q <= {ib_sync_q[1:0], interbyte_clock_in_i};
      if (ib_sync_q[2] == ib_sync_q[1]) begin
        ib_level_q <= ib_sync_q[2];
      end
    end
  end
  // forward the inter-byte clock level to neighbours
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clock_forward_down_o <= 1'b0;
      clock_forward_up_o <= 1'b0;
    end else begin
      clock_forward_down_o <= ib_level_q; // RULE_11
      clock_forward_up_o <= ib_level_q; // RULE_11
    end
  end
  // calibration sequencer on the control clock
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_q <= NPHY_CAL_IDLE;
      cal_cnt_q <= NPHY_CAL_RESET;
      cal_chain_start_out_o <= 1'b0;
      cal_chain_stop_out_o <= 1'b0;
      cal_done_o <= 1'b0;
    end else begin
      unique case (cal_q)
        NPHY_CAL_IDLE: begin
          cal_chain_start_out_o <= 1'b1;
          if (cal_chain_stop_in_i) begin // RULE_10
            cal_q <= NPHY_CAL_RUN; // RULE_05
          end
        end
        NPHY_CAL_RUN: begin
          cal_cnt_q <= cal_cnt_q + 1'b1;
          if (cal_cnt_q == 4'(NPHY_CAL_CYCLES - 1)) begin
            cal_q <= NPHY_CAL_DONE;
            cal_chain_stop_out_o <= 1'b1;
          end
        end
        NPHY_CAL_DONE: begin
          cal_done_o <= cal_chain_start_in_i; // RULE_09
        end
      endcase
    end
  end
  for (genvar n = 0; n < LANES; n++) begin : g_lane
    logic [NPHY_TAP_W-1:0] ld_val;
    logic [NPHY_TX_W-1:0] sh_q;
    logic [2:0] bit_q;
    logic loaded_q;
    logic [2:0] rx_sync_q;
    logic [NPHY_TX_W-1:0] rx_sh_q;
    logic [2:0] rx_bit_q;
    logic rx_push_q;
    logic [NPHY_TX_W-1:0] rx_word_q;
    logic fifo_ready;
    assign ld_val = link.delay_load_value[n*NPHY_TAP_W +: NPHY_TAP_W]; // RULE_02
    // per-lane delay updates
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        in_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] <= NPHY_TAP_RESET;
        out_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] <= NPHY_TAP_RESET;
      end else if (link.delay_load_strobe[n]) begin // RULE_01 RULE_04
        if (link.delay_direction_select) begin // RULE_03
          out_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] <= ld_val;
        end else begin
          in_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] <= ld_val;
        end
      end else if (link.step_enable[n]) begin // RULE_04
        if (link.delay_direction_select) begin
          out_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] <= link.step_up[n] ?
            out_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] + 1'b1 : out_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] - 1'b1;
        end else begin
          in_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] <= link.step_up[n] ?
            in_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] + 1'b1 : in_delay_taps_o[n*NPHY_TAP_W +: NPHY_TAP_W] - 1'b1;
        end
      end
    end
    // transmit serializer, lsb first
    assign link.tx_word_ready[n] = !loaded_q || (bit_q == 3'h7);
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sh_q <= '0;
        bit_q <= NPHY_BIT_RESET;
        loaded_q <= 1'b0;
        pad_serial_out_o[n] <= 1'b0;
      end else begin
        if (link.tx_word_valid[n] && link.tx_word_ready[n]) begin
          sh_q <= link.tx_word[n] >> 1;
          pad_serial_out_o[n] <= link.tx_word[n][0]; // RULE_08
          bit_q <= NPHY_BIT_RESET;
          loaded_q <= 1'b1;
        end else if (loaded_q) begin
          if (bit_q == 3'h7) begin
            loaded_q <= 1'b0;
          end else begin
            pad_serial_out_o[n] <= sh_q[0]; // RULE_08
            sh_q <= sh_q >> 1;
            bit_q <= bit_q + 1'b1;
          end
        end
      end
    end
    // receive capture: synchronise, deserialize, buffer
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        rx_sync_q <= 3'h0;
        rx_sh_q <= '0;
        rx_bit_q <= NPHY_BIT_RESET;
        rx_push_q <= 1'b0;
        rx_word_q <= '0;
      end else begin
        rx_sync_q <= {rx_sync_q[1:0], rx_pad_bits_i[n]}; // RULE_07
        rx_push_q <= 1'b0;
        if (rx_sync_q[2] == rx_sync_q[1]) begin
          rx_sh_q <= {rx_sync_q[2], rx_sh_q[NPHY_TX_W-1:1]};
          rx_bit_q <= rx_bit_q + 1'b1;
          if (rx_bit_q == 3'h7) begin
            rx_word_q <= {rx_sync_q[2], rx_sh_q[NPHY_TX_W-1:1]};
            rx_push_q <= 1'b1;
          end
        end
      end
    end
    nphy_fifo #(.WIDTH(NPHY_TX_W), .DEPTH(DEPTH)) u_fifo (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .in_data_i(rx_word_q),
      .in_valid_i(rx_push_q),
      .in_ready_o(fifo_ready),
      .out_data_o(link.rx_word[n]), // RULE_07
      .out_valid_o(link.rx_word_valid[n]),
      .out_ready_i(link.lane_fifo_read_enable[n]) // RULE_12
    );
  end
endmodule : nphy_device

// File: nphy_fabric.sv
`timescale 1ns/1ps
module nphy_fabric
  import nphy_pkg::*;
#(
  parameter int LANES = NPHY_LANES
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  nphy_if.fabric link,
  input wire logic [LANES-1:0] step_enable_i,
  input wire logic [LANES-1:0] step_up_i,
  input wire logic [LANES-1:0] load_i,
  input wire logic [LANES*NPHY_TAP_W-1:0] load_value_i,
  input wire logic direction_select_i,
  input wire logic [LANES*NPHY_TX_W-1:0] tx_data_i,
  input wire logic [LANES-1:0] tx_valid_i,
  output logic [LANES-1:0] tx_ready_o,
  input wire logic [LANES-1:0] rx_take_i,
  output logic [LANES*NPHY_TX_W-1:0] rx_data_o,
  output logic [LANES-1:0] rx_valid_o
);
  // delay controls registered on the control clock
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.step_enable <= '0;
      link.step_up <= '0;
      link.delay_load_strobe <= '0;
      link.delay_load_value <= '0;
      link.delay_direction_select <= 1'b0;
    end else begin
      link.step_enable <= step_enable_i; // RULE_04
      link.step_up <= step_up_i;
      link.delay_load_strobe <= load_i;
      link.delay_load_value <= load_value_i; // RULE_02
      link.delay_direction_select <= direction_select_i;
    end
  end
  for (genvar n = 0; n < LANES; n++) begin : g_lane
    assign link.tx_word[n] = tx_data_i[n*NPHY_TX_W +: NPHY_TX_W];
    assign link.tx_word_valid[n] = tx_valid_i[n];
    assign link.lane_fifo_read_enable[n] = rx_take_i[n] && link.rx_word_valid[n]; // RULE_12
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        tx_ready_o[n] <= 1'b0;
        rx_valid_o[n] <= 1'b0;
        rx_data_o[n*NPHY_TX_W +: NPHY_TX_W] <= '0;
      end else begin
        tx_ready_o[n] <= link.tx_word_ready[n];
        rx_valid_o[n] <= link.lane_fifo_read_enable[n];
        if (link.lane_fifo_read_enable[n]) begin
          rx_data_o[n*NPHY_TX_W +: NPHY_TX_W] <= link.rx_word[n];
        end
      end
    end
  end
endmodule : nphy_fabric

// File: nphy_assertions.sv
`timescale 1ns/1ps
module nphy_assertions
  import nphy_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [NPHY_LANES-1:0] tx_word_valid,
  input wire logic [NPHY_LANES-1:0] tx_word_ready,
  input wire logic [NPHY_LANES-1:0] lane_fifo_read_enable,
  input wire logic [NPHY_LANES-1:0] rx_word_valid,
  input wire logic [NPHY_TX_W-1:0] rx_word [NPHY_LANES]
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [3:0] up_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hF) begin
      up_q <= up_q + 4'h1;
    end
  end
  a_rx_quiet_start: assert property (up_q < 4'h8 |-> rx_word_valid == '0) else $error("rx word too early");
  a_lanes_apart: assert property ((~tx_word_ready & $past(tx_word_ready) & ~$past(tx_word_valid)) == '0)
    else $error("tx ready fell without own take");
  for (genvar n = 0; n < NPHY_LANES; n++) begin : g_lane
    sequence s_take;
      tx_word_valid[n] && tx_word_ready[n];
    endsequence
    sequence s_busy;
      !tx_word_ready[n] [*6];
    endsequence
    a_tx_busy: assert property (s_take |=> s_busy) else $error("tx ready back too early");
    a_tx_return: assert property (s_take |-> ##[1:9] tx_word_ready[n]) else $error("tx ready stuck low");
    a_tx_idle_hold: assert property (tx_word_ready[n] && !tx_word_valid[n] |=> tx_word_ready[n])
      else $error("tx ready dropped while idle");
    a_rx_hold: assert property (rx_word_valid[n] && !lane_fifo_read_enable[n] |=> rx_word_valid[n])
      else $error("rx word lost unread");
    a_rx_head_stable: assert property (rx_word_valid[n] && !lane_fifo_read_enable[n] |=> $stable(rx_word[n]))
      else $error("rx head changed unread");
    a_rx_pop_only: assert property ($fell(rx_word_valid[n]) |-> $past(lane_fifo_read_enable[n]))
      else $error("rx valid fell without read");
  end
endmodule : nphy_assertions

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import nphy_pkg::*;
  logic core_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [5:0] step_en = '0, step_up = '0, load = '0, tx_valid = '0, rx_take = '0, rx_pad = 6'h2A, rx_valid, pad, tx_rdy;
  logic [53:0] load_value = '0, in_taps, out_taps, exp_in = '0, exp_out = '0;
  logic [47:0] tx_data = '0, rx_data;
  logic [7:0] got;
  logic dir_sel = 1'h0, stop_out, cal_done, fwd_dn, fwd_up, start_out;
  int miscompares = 0, total_checks = 0;
  nphy_if link();
  nphy_device nphy_device_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(link.device), .rx_pad_bits_i(rx_pad),
    .pad_serial_out_o(pad), .cal_chain_start_in_i(stop_out), .cal_chain_stop_in_i(1'h1),
    .cal_chain_start_out_o(start_out), .cal_chain_stop_out_o(stop_out), .interbyte_clock_in_i(1'h1),
    .clock_forward_down_o(fwd_dn), .clock_forward_up_o(fwd_up),
    .in_delay_taps_o(in_taps), .out_delay_taps_o(out_taps), .cal_done_o(cal_done));
  nphy_fabric nphy_fabric_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(link.fabric), .step_enable_i(step_en),
    .step_up_i(step_up), .load_i(load), .load_value_i(load_value), .direction_select_i(dir_sel), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_rdy), .rx_take_i(rx_take), .rx_data_o(rx_data), .rx_valid_o(rx_valid));
  nphy_assertions nphy_assertions_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .tx_word_valid(link.tx_word_valid),
    .tx_word_ready(link.tx_word_ready), .lane_fifo_read_enable(link.lane_fifo_read_enable),
    .rx_word_valid(link.rx_word_valid), .rx_word(link.rx_word));
  // one control clock for the whole bank, so the ratio stays 1:1
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic load_lane(input int n, input logic d, input logic [8:0] v);
    tick();
    dir_sel = d;
    load = 6'h01 << n;
    load_value[9*n +: 9] = v;
    if (d) begin
      exp_out[9*n +: 9] = v;
    end else begin
      exp_in[9*n +: 9] = v;
    end
    tick();
    load = '0;
  endtask : load_lane
  task automatic send(input int n, input logic [7:0] w);
    int i;
    tx_data[8*n +: 8] = w;
    tx_valid[n] = 1'h1;
    i = 0;
    while (link.tx_word_ready[n] !== 1'h1 && i < 20) begin
      @(negedge core_clk_i);
      i++;
    end
    check("tx ready", 1'h1, link.tx_word_ready[n]);
    tick();
    tx_valid[n] = 1'h0;
    for (i = 0; i < 8; i++) begin
      check("pad bit", w[i], pad[n]);
      tick();
    end
  endtask : send
  task automatic take(input int n, output logic [7:0] w);
    int i;
    tick();
    rx_take[n] = 1'h1;
    tick();
    rx_take[n] = 1'h0;
    i = 0;
    while (rx_valid[n] !== 1'h1 && i < 4) begin
      tick();
      i++;
    end
    check("rx valid", 1'h1, rx_valid[n]);
    w = rx_data[8*n +: 8];
  endtask : take
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1;
    resetn_i = 1'h1;
    for (int n = 0; n < 6; n++) begin
      load_lane(n, 1'h0, 9'h1FF - 9'(n * 37));
      load_lane(n, 1'h1, 9'(n * 61));
    end
    repeat (3) tick();
    check("input taps", exp_in, in_taps);
    check("output taps", exp_out, out_taps);
    step_en = 6'h08;
    step_up = 6'h08;
    tick();
    step_en = '0;
    repeat (3) tick();
    check("stepped tap", exp_out[35:27] + 9'h001, out_taps[35:27]);
    check("other taps", exp_out[26:0], out_taps[26:0]);
    dir_sel = 1'h0;
    step_en = 6'h01;
    step_up = '0;
    tick();
    step_en = '0;
    repeat (3) tick();
    check("stepped down", exp_in[8:0] - 9'h001, in_taps[8:0]);
    repeat (30) tick();
    check("cal done", 1'h1, cal_done);
    check("start out", 1'h1, start_out);
    check("forward down", 1'h1, fwd_dn);
    check("forward up", 1'h1, fwd_up);
    for (int n = 0; n < 6; n++) begin
      send(n, 8'h3C ^ 8'(n * 17));
    end
    send(2, 8'h80);
    send(2, 8'h01);
    repeat (200) tick();
    check("tx ready out", 6'h3F, tx_rdy);
    for (int n = 0; n < 6; n++) begin
      for (int k = 0; k < 16; k++) begin
        take(n, got);
        if (k > 0) check("rx word", rx_pad[n] ? 8'hFF : 8'h00, got);
      end
    end
    close_out();
  end
endmodule : tb
